// *** mcu8_transfer_decoder_tb.sv ***
// self-checking bench for the byte-transfer execute core
`timescale 1ns/100ps
`default_nettype none

module mcu8_transfer_decoder_tb;
  localparam int NINSN = 40;
  localparam int SUBP  = 4;
  logic        clk, srst, run, pld, ack, rd, wr, done, uns, usub, stick;
  logic [1:0]  psel, gear, slow;
  logic [15:0] pdat, addr, acc, tmp, ix, ep, sp, psw, pc;
  logic [7:0]  rdata, wdata;
  logic [7:0]  rm [0:65535];
  logic [15:0] racc, rtmp, rix, rep, rsp, rpc, rpsw;
  int          num_errors, n_checks, cycles;
  logic [7:0]  ops [0:16] = '{8'h04, 8'h05, 8'h06, 8'h60, 8'h92, 8'h07,
    8'h08, 8'h45, 8'h46, 8'h61, 8'h47, 8'h48, 8'h85, 8'h86, 8'h87, 8'h00,
    8'hC5};

  mtd_core mtd_core_inst (.SYS_CLK_I(clk), .SRST_I(srst), .RUN_I(run),
    .USE_SUBCLK_I(usub), .GEAR_SEL_I(gear), .SUBCLK_TICK_I(stick),
    .PTR_LOAD_I(pld), .PTR_SEL_I(psel), .PTR_DATA_I(pdat),
    .MEM_RDATA_I(rdata), .MEM_ACK_I(ack), .MEM_ADDR_O(addr),
    .MEM_RD_O(rd), .MEM_WR_O(wr), .MEM_WDATA_O(wdata), .ACC_O(acc),
    .TEMP_O(tmp), .IX_O(ix), .EP_O(ep), .SP_O(sp), .PSW_O(psw), .PC_O(pc),
    .INSN_DONE_O(done), .UNSUPPORTED_O(uns));
  mtd_mem_model mtd_mem_model_inst (.clk_i(clk), .rd_i(rd), .wr_i(wr),
    .addr_i(addr), .wdata_i(wdata), .wait_i(slow), .rdata_o(rdata),
    .ack_o(ack));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // byte count times 8 plus cycle count; outside the group is 1 and 1
  function automatic int code_of(input logic [7:0] op);
    case (op)
      8'h04:               return 18;
      8'h05, 8'h45:        return 19;
      8'h06, 8'h46:        return 20;
      8'h60, 8'h61, 8'h85: return 28;
      8'h86:               return 29;
      8'h87:               return 20;
      8'h92, 8'h07, 8'h47: return 11;
      default: return (op[7:3] == 5'h01 || op[7:3] == 5'h09) ? 11 : 9;
    endcase
  endfunction : code_of

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    rm[a] = d;
    mtd_mem_model_inst.mem[a] = d;
  endtask : put

  task automatic load_ptr(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    #1 pld = 1'b1;
    psel = s;
    pdat = d;
    @(posedge clk);
    #1 pld = 1'b0;
  endtask : load_ptr

  // reference execution of the instruction at the reference pc
  task automatic ref_step(output int nc, output logic xu);
    logic [7:0]  op, b1, b2, v;
    logic [15:0] ea;
    logic        ld, st;
    op = rm[rpc];
    b1 = rm[rpc + 16'h1];
    b2 = rm[rpc + 16'h2];
    nc = code_of(op) % 8;
    v  = racc[7:0];
    ea = {8'h01, rpsw[15:11], op[2:0]};
    ld = op inside {8'h04, 8'h05, 8'h06, 8'h60, 8'h92, 8'h07} ||
         op[7:3] == 5'h01;
    st = op inside {8'h45, 8'h46, 8'h61, 8'h47, 8'h85, 8'h86, 8'h87} ||
         op[7:3] == 5'h09;
    case (op)
      8'h04:        v = b1;
      8'h05, 8'h45: ea = {8'h00, b1};
      8'h85:        {ea, v} = {8'h00, b1, b2};
      8'h06, 8'h46: ea = rix + {8'h00, b1};
      8'h86:        {ea, v} = {rix + {8'h00, b1}, b2};
      8'h60, 8'h61: ea = {b1, b2};
      8'h92:        ea = racc;
      8'h07, 8'h47: ea = rep;
      8'h87:        {ea, v} = {rep, b1};
      default:      ;
    endcase
    if (ld) begin
      if (op != 8'h04) v = rm[ea];
      rtmp[7:0] = racc[7:0];
      racc[7:0] = v;
      rpsw[3]   = v[7];
      rpsw[2]   = (v == 8'h00);
    end else if (st) begin
      rm[ea] = v;
      check({8'h00, mtd_mem_model_inst.mem[ea]}, {8'h00, v});
    end
    xu  = !(ld || st);
    rpc = rpc + 16'(code_of(op) / 8);
  endtask : ref_step

  // ----------------------------------------------------------------
  // clock, memory stall pattern and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    #1 slow = 2'($urandom_range(3, 0));
    stick = (cycles % SUBP == 0);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  op, b1;
    logic [15:0] p;
    int          nc, t0, dv;
    logic        xu;
    void'($urandom(32'h1e62));
    {srst, run, pld, psel, pdat, usub} = {3'b100, 2'h0, 16'h0000, 1'b0};
    {num_errors, n_checks} = {32'd0, 32'd0};
    gear = 2'($urandom_range(3, 0));
    for (int i = 0; i < 65536; i++) put(16'(i), 8'($urandom));
    p = 16'h0000;
    for (int i = 0; i < NINSN; i++) begin
      op = (i < 17) ? ops[i] : ops[$urandom_range(16, 0)];
      if (op[7:3] == 5'h01 || op[7:3] == 5'h09) op[2:0] = 3'($urandom);
      b1 = 8'($urandom);
      if (op == 8'h04 && i < 17) b1 = 8'h00;
      if (op inside {8'h05, 8'h45, 8'h85}) b1[7] = 1'b1;
      if (op inside {8'h60, 8'h61}) b1[7:6] = 2'b01;
      put(p, op);
      put(p + 16'h1, b1);
      put(p + 16'h2, 8'($urandom));
      p = p + 16'(code_of(op) / 8);
    end
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    @(negedge clk);
    check(acc | tmp | psw | pc | ix | ep | sp, 16'h0000);
    {racc, rtmp, rpc} = {16'h0000, 16'h0000, 16'h0000};
    rix  = {8'h20, 8'($urandom)};
    rep  = {8'h30, 8'($urandom)};
    rsp  = 16'($urandom);
    rpsw = {5'($urandom), 11'h000};
    load_ptr(2'h0, rix);
    load_ptr(2'h1, rep);
    load_ptr(2'h2, rsp);
    load_ptr(2'h3, rpsw);
    @(negedge clk);
    check(ix, rix);
    check(ep, rep);
    check(sp, rsp);
    check(psw, rpsw);
    @(posedge clk);
    #1 run = 1'b1;
    for (int i = 0; i < NINSN; i++) begin
      // second half runs from subclock pulses; pause so no fetch straddles
      if (i == NINSN / 2) begin
        {run, usub} = 2'b01;
        @(posedge clk);
        #1 run = 1'b1;
      end
      // gear moves only between instructions, ticks keep their spacing
      if (!usub) gear = 2'($urandom_range(3, 0));
      dv = usub ? 2 * SUBP : (gear == 2'h3) ? 64 : (4 << gear);
      t0 = cycles;
      do begin
        @(posedge clk);
        #1;
      end while (done !== 1'b1);
      ref_step(nc, xu);
      check(16'(cycles - t0 >= (nc - 1) * dv), 16'h0001);
      check(acc, racc);
      check(tmp, rtmp);
      check(psw, rpsw);
      check(pc, rpc);
      check({15'h0000, uns}, {15'h0000, xu});
    end
    print_verdict();
  end
endmodule : mcu8_transfer_decoder_tb
`default_nettype wire

// *** mtd_core.sv ***
// byte-transfer execute core: fetch, operand gather, memory access
`timescale 1ns/100ps
`default_nettype none
`include "mtd_map.svh"

module mtd_core (
  input  wire logic        SYS_CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        RUN_I,
  input  wire logic        USE_SUBCLK_I,
  input  wire logic [1:0]  GEAR_SEL_I,
  input  wire logic        SUBCLK_TICK_I,
  input  wire logic        PTR_LOAD_I,
  input  wire logic [1:0]  PTR_SEL_I,
  input  wire logic [15:0] PTR_DATA_I,
  input  wire logic [7:0]  MEM_RDATA_I,
  input  wire logic        MEM_ACK_I,
  output logic      [15:0] MEM_ADDR_O,
  output logic             MEM_RD_O,
  output logic             MEM_WR_O,
  output logic      [7:0]  MEM_WDATA_O,
  output logic      [15:0] ACC_O,
  output logic      [15:0] TEMP_O,
  output logic      [15:0] IX_O,
  output logic      [15:0] EP_O,
  output logic      [15:0] SP_O,
  output logic      [15:0] PSW_O,
  output logic      [15:0] PC_O,
  output logic             INSN_DONE_O,
  output logic             UNSUPPORTED_O
);

  mtd_pkg::mtd_core_state_t st_r;
  mtd_pkg::mtd_core_state_t st_nxt;
  mtd_pkg::mtd_dec_t        dec;
  logic                     tick;
  logic [15:0]              ea;
  logic [7:0]               imm;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  mtd_tick_gen u_tick (
    .clk_i      (SYS_CLK_I),
    .srst_i     (SRST_I),
    .use_sub_i  (USE_SUBCLK_I),
    .gear_i     (GEAR_SEL_I),
    .sub_tick_i (SUBCLK_TICK_I),
    .tick_o     (tick)
  );

  mtd_decode u_dec (
    .opcode_i (st_r.opcode),
    .dec_o    (dec)
  );

  function automatic mtd_pkg::mtd_mem_t req(
    input logic [15:0] a,
    input logic        w,
    input logic [7:0]  d
  );
    mtd_pkg::mtd_mem_t m;
    m.addr  = a;
    m.rd    = !w;
    m.wr    = w;
    m.wdata = d;
    return m;
  endfunction : req

  // ----------------------------------------------------------------
  // effective address and immediate source
  // ----------------------------------------------------------------
  always_comb begin
    ea = 16'h0000;
    unique case (dec.mode)
      mtd_pkg::M_IMM: ea = 16'h0000;
      mtd_pkg::M_DIR: ea = {8'h00, st_r.opnd0};
      mtd_pkg::M_IXO: ea = st_r.ix + {8'h00, st_r.opnd0};
      mtd_pkg::M_EXT: ea = {st_r.opnd0, st_r.opnd1};
      mtd_pkg::M_ACC: ea = st_r.acc;
      mtd_pkg::M_EPI: ea = st_r.ep;
      mtd_pkg::M_REG: ea = {`MTD_BANK_BASE, st_r.psw.bank, dec.ridx};
      default:        ea = 16'h0000;
    endcase
    // the immediate is written after any address byte
    imm = (dec.mode == mtd_pkg::M_EPI) ? st_r.opnd0 : st_r.opnd1;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.done  = 1'b0;
    st_nxt.unsup = 1'b0;
    if (tick && st_r.cyc != `MTD_CY_MAX) begin
      st_nxt.cyc = st_r.cyc + 3'h1;
    end
    unique case (st_r.fsm)
      mtd_pkg::S_IDLE: begin
        if (PTR_LOAD_I) begin
          unique case (PTR_SEL_I)
            `MTD_SEL_IX: st_nxt.ix  = PTR_DATA_I;
            `MTD_SEL_EP: st_nxt.ep  = PTR_DATA_I;
            `MTD_SEL_SP: st_nxt.sp  = PTR_DATA_I;
            `MTD_SEL_PS: st_nxt.psw = PTR_DATA_I;
          endcase
        end else if (RUN_I) begin
          st_nxt.cyc = 3'h0;
          st_nxt.mem = req(st_r.pc, 1'b0, 8'h00);
          st_nxt.fsm = mtd_pkg::S_FETCH;
        end
      end
      mtd_pkg::S_FETCH: begin
        if (MEM_ACK_I) begin
          st_nxt.opcode = MEM_RDATA_I;
          st_nxt.pc     = st_r.pc + 16'h0001;
          st_nxt.mem.rd = 1'b0;
          st_nxt.ocnt   = 2'h0;
          st_nxt.fsm    = mtd_pkg::S_DEC;
        end
      end
      mtd_pkg::S_DEC: begin
        st_nxt.fsm = mtd_pkg::S_OPND;
      end
      mtd_pkg::S_OPND: begin
        // one idle cycle between reads keeps each request distinct
        if (st_r.mem.rd) begin
          if (MEM_ACK_I) begin
            if (st_r.ocnt == 2'h0) begin
              st_nxt.opnd0 = MEM_RDATA_I;
            end else begin
              st_nxt.opnd1 = MEM_RDATA_I;
            end
            st_nxt.pc     = st_r.pc + 16'h0001;
            st_nxt.ocnt   = st_r.ocnt + 2'h1;
            st_nxt.mem.rd = 1'b0;
          end
        end else if (st_r.ocnt == dec.nbytes - 2'h1) begin
          st_nxt.fsm = mtd_pkg::S_ADDR;
        end else begin
          st_nxt.mem = req(st_r.pc, 1'b0, 8'h00);
        end
      end
      mtd_pkg::S_ADDR: begin
        st_nxt.fsm = mtd_pkg::S_MEM;
        unique case (dec.kind)
          mtd_pkg::K_LD: begin
            if (dec.mode == mtd_pkg::M_IMM) begin
              st_nxt.rdata = st_r.opnd0;
              st_nxt.fsm   = mtd_pkg::S_WAIT;
            end else begin
              st_nxt.mem = req(ea, 1'b0, 8'h00);
            end
          end
          mtd_pkg::K_ST: st_nxt.mem = req(ea, 1'b1, st_r.acc.lo);
          mtd_pkg::K_MI: st_nxt.mem = req(ea, 1'b1, imm);
          mtd_pkg::K_NONE: st_nxt.fsm = mtd_pkg::S_WAIT;
        endcase
      end
      mtd_pkg::S_MEM: begin
        if (MEM_ACK_I) begin
          st_nxt.rdata  = MEM_RDATA_I;
          st_nxt.mem.rd = 1'b0;
          st_nxt.mem.wr = 1'b0;
          st_nxt.fsm    = mtd_pkg::S_WAIT;
        end
      end
      mtd_pkg::S_WAIT: begin
        // the instruction ends once its count of instruction cycles ran
        if (st_r.cyc >= dec.ncyc) begin
          st_nxt.done  = 1'b1;
          st_nxt.unsup = (dec.kind == mtd_pkg::K_NONE);
          st_nxt.fsm   = mtd_pkg::S_IDLE;
          if (dec.kind == mtd_pkg::K_LD) begin
            st_nxt.tmp.lo = st_r.acc.lo;
            st_nxt.acc.lo = st_r.rdata;
            st_nxt.psw.flags[`MTD_CCR_N] = st_r.rdata[7];
            st_nxt.psw.flags[`MTD_CCR_Z] = (st_r.rdata == 8'h00);
          end
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign MEM_ADDR_O    = st_r.mem.addr;
  assign MEM_RD_O      = st_r.mem.rd;
  assign MEM_WR_O      = st_r.mem.wr;
  assign MEM_WDATA_O   = st_r.mem.wdata;
  assign ACC_O         = st_r.acc;
  assign TEMP_O        = st_r.tmp;
  assign IX_O          = st_r.ix;
  assign EP_O          = st_r.ep;
  assign SP_O          = st_r.sp;
  assign PSW_O         = st_r.psw;
  assign PC_O          = st_r.pc;
  assign INSN_DONE_O   = st_r.done;
  assign UNSUPPORTED_O = st_r.unsup;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0]            pc_start;
  mtd_pkg::mtd_word_t     snap_acc;
  mtd_pkg::mtd_word_t     snap_tmp;
  logic [7:0]             snap_flags;

  always_ff @(posedge SYS_CLK_I) begin
    if (st_r.fsm == mtd_pkg::S_IDLE) begin
      pc_start <= st_r.pc;
    end
    if (st_r.fsm == mtd_pkg::S_DEC) begin
      snap_acc   <= st_r.acc;
      snap_tmp   <= st_r.tmp;
      snap_flags <= st_r.psw.flags;
    end
  end

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SRST_I);

  pc_advance_a: assert property (
    st_r.done |-> st_r.pc == pc_start + {14'h0000, dec.nbytes})
    else $error("pc did not advance by the instruction length");

  temp_low_a: assert property (
    st_r.done && dec.kind == mtd_pkg::K_LD
    |-> st_r.tmp.lo == snap_acc.lo && st_r.tmp.hi == snap_tmp.hi)
    else $error("temp accumulator not loaded from old low byte");

  acc_high_a: assert property (
    st_r.done && dec.kind == mtd_pkg::K_LD |-> st_r.acc.hi == snap_acc.hi)
    else $error("accumulator high byte changed on byte load");

  load_flags_a: assert property (
    st_r.done && dec.kind == mtd_pkg::K_LD
    |-> st_r.psw.flags[`MTD_CCR_N] == st_r.acc.lo[7]
        && st_r.psw.flags[`MTD_CCR_Z] == (st_r.acc.lo == 8'h00))
    else $error("load flags do not match loaded byte");

  store_flags_a: assert property (
    st_r.done && (dec.kind == mtd_pkg::K_ST || dec.kind == mtd_pkg::K_MI)
    |-> st_r.psw.flags == snap_flags)
    else $error("flags changed on a byte store");

  store_data_a: assert property (
    MEM_WR_O && dec.kind == mtd_pkg::K_ST |-> MEM_WDATA_O == ACC_O[7:0])
    else $error("store does not write accumulator low byte");

  imm_store_a: assert property (
    MEM_WR_O && dec.kind == mtd_pkg::K_MI
    && dec.mode == mtd_pkg::M_DIR
    |-> MEM_WDATA_O == st_r.opnd1 && MEM_ADDR_O == {8'h00, st_r.opnd0})
    else $error("immediate-to-direct move wrote wrong byte or place");

  direct_page_a: assert property (
    (MEM_RD_O || MEM_WR_O) && st_r.fsm == mtd_pkg::S_MEM
    && dec.mode == mtd_pkg::M_DIR |-> MEM_ADDR_O[15:8] == 8'h00)
    else $error("direct access left the low page");

  long_addr_a: assert property (
    (MEM_RD_O || MEM_WR_O) && st_r.fsm == mtd_pkg::S_MEM
    && dec.mode == mtd_pkg::M_EXT
    |-> MEM_ADDR_O == {st_r.opnd0, st_r.opnd1})
    else $error("long address not built from both operand bytes");

  cycle_count_a: assert property (
    $rose(st_r.done) |-> $past(st_r.cyc) >= dec.ncyc)
    else $error("instruction ended before its cycle count");

  req_hold_a: assert property (
    (MEM_RD_O || MEM_WR_O) && !MEM_ACK_I
    |=> (MEM_RD_O || MEM_WR_O) && $stable(MEM_ADDR_O))
    else $error("bus request dropped before acknowledge");

  fetch_addr_a: assert property (
    MEM_RD_O
    && (st_r.fsm == mtd_pkg::S_FETCH || st_r.fsm == mtd_pkg::S_OPND)
    |-> MEM_ADDR_O == PC_O)
    else $error("code fetch not at the program counter");

  imm_ixo_a: assert property (
    MEM_WR_O && dec.kind == mtd_pkg::K_MI && dec.mode == mtd_pkg::M_IXO
    |-> MEM_WDATA_O == st_r.opnd1
        && MEM_ADDR_O == IX_O + {8'h00, st_r.opnd0})
    else $error("indexed immediate move took operands out of order");

  imm_epi_a: assert property (
    MEM_WR_O && dec.kind == mtd_pkg::K_MI && dec.mode == mtd_pkg::M_EPI
    |-> MEM_WDATA_O == st_r.opnd0 && MEM_ADDR_O == EP_O)
    else $error("pointer immediate move wrote wrong byte or place");

  bank_addr_a: assert property (
    (MEM_RD_O || MEM_WR_O) && st_r.fsm == mtd_pkg::S_MEM
    && dec.mode == mtd_pkg::M_REG
    |-> MEM_ADDR_O == {`MTD_BANK_BASE, PSW_O[15:11], st_r.opcode[2:0]})
    else $error("register access outside the selected bank");

endmodule : mtd_core
`default_nettype wire

// *** mtd_decode.sv ***
// opcode decoder for the byte-transfer group
`timescale 1ns/100ps
`default_nettype none
`include "mtd_map.svh"

module mtd_decode (
  input  wire logic [7:0]   opcode_i,
  output mtd_pkg::mtd_dec_t dec_o
);

  function automatic mtd_pkg::mtd_dec_t ent(
    input mtd_pkg::mtd_kind_t k,
    input mtd_pkg::mtd_mode_t m,
    input logic [1:0]         nb,
    input logic [2:0]         nc,
    input logic [2:0]         ri
  );
    mtd_pkg::mtd_dec_t d;
    d.kind   = k;
    d.mode   = m;
    d.nbytes = nb;
    d.ncyc   = nc;
    d.ridx   = ri;
    return d;
  endfunction : ent

  // ----------------------------------------------------------------
  // decode table
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] ri;
    ri    = opcode_i[2:0];
    // anything outside the group is skipped as a one-byte, one-cycle op
    dec_o = ent(mtd_pkg::K_NONE, mtd_pkg::M_IMM, `MTD_NB_1, `MTD_CY_1, ri);
    if (opcode_i[7:3] == `MTD_OPH_ST_REG) begin
      dec_o = ent(mtd_pkg::K_ST, mtd_pkg::M_REG, `MTD_NB_1, `MTD_CY_3, ri);
    end else if (opcode_i[7:3] == `MTD_OPH_LD_REG) begin
      dec_o = ent(mtd_pkg::K_LD, mtd_pkg::M_REG, `MTD_NB_1, `MTD_CY_3, ri);
    end else begin
      unique case (opcode_i)
        `MTD_OP_ST_DIR: dec_o = ent(mtd_pkg::K_ST, mtd_pkg::M_DIR,
                                    `MTD_NB_2, `MTD_CY_3, ri);
        `MTD_OP_ST_IXO: dec_o = ent(mtd_pkg::K_ST, mtd_pkg::M_IXO,
                                    `MTD_NB_2, `MTD_CY_4, ri);
        `MTD_OP_ST_EXT: dec_o = ent(mtd_pkg::K_ST, mtd_pkg::M_EXT,
                                    `MTD_NB_3, `MTD_CY_4, ri);
        `MTD_OP_ST_EPI: dec_o = ent(mtd_pkg::K_ST, mtd_pkg::M_EPI,
                                    `MTD_NB_1, `MTD_CY_3, ri);
        `MTD_OP_LD_IMM: dec_o = ent(mtd_pkg::K_LD, mtd_pkg::M_IMM,
                                    `MTD_NB_2, `MTD_CY_2, ri);
        `MTD_OP_LD_DIR: dec_o = ent(mtd_pkg::K_LD, mtd_pkg::M_DIR,
                                    `MTD_NB_2, `MTD_CY_3, ri);
        `MTD_OP_LD_IXO: dec_o = ent(mtd_pkg::K_LD, mtd_pkg::M_IXO,
                                    `MTD_NB_2, `MTD_CY_4, ri);
        `MTD_OP_LD_EXT: dec_o = ent(mtd_pkg::K_LD, mtd_pkg::M_EXT,
                                    `MTD_NB_3, `MTD_CY_4, ri);
        `MTD_OP_LD_ACC: dec_o = ent(mtd_pkg::K_LD, mtd_pkg::M_ACC,
                                    `MTD_NB_1, `MTD_CY_3, ri);
        `MTD_OP_LD_EPI: dec_o = ent(mtd_pkg::K_LD, mtd_pkg::M_EPI,
                                    `MTD_NB_1, `MTD_CY_3, ri);
        `MTD_OP_MI_DIR: dec_o = ent(mtd_pkg::K_MI, mtd_pkg::M_DIR,
                                    `MTD_NB_3, `MTD_CY_4, ri);
        `MTD_OP_MI_IXO: dec_o = ent(mtd_pkg::K_MI, mtd_pkg::M_IXO,
                                    `MTD_NB_3, `MTD_CY_5, ri);
        `MTD_OP_MI_EPI: dec_o = ent(mtd_pkg::K_MI, mtd_pkg::M_EPI,
                                    `MTD_NB_2, `MTD_CY_4, ri);
        default: ;
      endcase
    end
  end

endmodule : mtd_decode
`default_nettype wire

// *** mtd_map.svh ***
// constants for the byte-transfer decode and execute block
`ifndef MTD_MAP_SVH
`define MTD_MAP_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define MTD_OP_ST_DIR   8'h45
`define MTD_OP_ST_IXO   8'h46
`define MTD_OP_ST_EXT   8'h61
`define MTD_OP_ST_EPI   8'h47
`define MTD_OPH_ST_REG  5'h09
`define MTD_OP_LD_IMM   8'h04
`define MTD_OP_LD_DIR   8'h05
`define MTD_OP_LD_IXO   8'h06
`define MTD_OP_LD_EXT   8'h60
`define MTD_OP_LD_ACC   8'h92
`define MTD_OP_LD_EPI   8'h07
`define MTD_OPH_LD_REG  5'h01
`define MTD_OP_MI_DIR   8'h85
`define MTD_OP_MI_IXO   8'h86
`define MTD_OP_MI_EPI   8'h87

// ----------------------------------------------------------------
// byte counts and instruction cycle counts
// ----------------------------------------------------------------
`define MTD_NB_1        2'h1
`define MTD_NB_2        2'h2
`define MTD_NB_3        2'h3
`define MTD_CY_1        3'h1
`define MTD_CY_2        3'h2
`define MTD_CY_3        3'h3
`define MTD_CY_4        3'h4
`define MTD_CY_5        3'h5
`define MTD_CY_MAX      3'h7

// ----------------------------------------------------------------
// instruction cycle dividers, in oscillator periods; MTD_DIV_SUB in subclock periods
// ----------------------------------------------------------------
`define MTD_DIV_G0      7'h04
`define MTD_DIV_G1      7'h08
`define MTD_DIV_G2      7'h10
`define MTD_DIV_G3      7'h40
`define MTD_DIV_SUB     7'h02

// ----------------------------------------------------------------
// layout
// ----------------------------------------------------------------
`define MTD_BANK_BASE   8'h01
`define MTD_CCR_N       3
`define MTD_CCR_Z       2
`define MTD_SEL_IX      2'h0
`define MTD_SEL_EP      2'h1
`define MTD_SEL_SP      2'h2
`define MTD_SEL_PS      2'h3

`endif

// *** mtd_mem_model.sv ***
// program and data memory answering the core's byte bus
`timescale 1ns/100ps
`default_nettype none

module mtd_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [1:0]  wait_i,
  output logic      [7:0]  rdata_o,
  output logic             ack_o
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt_r;

  initial begin
    ack_o   = 1'b0;
    rdata_o = 8'h00;
    cnt_r   = 2'h0;
  end

  // read data flips every cycle outside a read ack so a stale sample shows up
  always @(posedge clk_i) begin
    rdata_o <= ~rdata_o;
    ack_o   <= 1'b0;
    cnt_r   <= 2'h0;
    if ((rd_i || wr_i) && !ack_o) begin
      if (cnt_r < wait_i) begin
        cnt_r <= cnt_r + 2'h1;
      end else begin
        ack_o <= 1'b1;
        if (rd_i) rdata_o <= mem[addr_i];
        if (wr_i) mem[addr_i] <= wdata_i;
      end
    end
  end
endmodule : mtd_mem_model
`default_nettype wire

// *** mtd_pkg.sv ***
// types shared by the byte-transfer decode and execute block
package mtd_pkg;

  typedef enum logic [1:0] {K_NONE, K_LD, K_ST, K_MI} mtd_kind_t;
  typedef enum logic [2:0] {
    M_IMM, M_DIR, M_IXO, M_EXT, M_ACC, M_EPI, M_REG
  } mtd_mode_t;
  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_DEC, S_OPND, S_ADDR, S_MEM, S_WAIT
  } mtd_fsm_t;

  // operand formats
  typedef logic [7:0]        mtd_dir_t;
  typedef logic [15:0]       mtd_ext_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] bit_idx;
  } mtd_bitop_t;
  typedef logic [2:0]        mtd_vec_t;
  typedef logic signed [7:0] mtd_rel_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } mtd_word_t;

  typedef struct packed {
    logic [4:0] bank;
    logic [2:0] rsv;
    logic [7:0] flags;
  } mtd_psw_t;

  typedef struct packed {
    mtd_kind_t  kind;
    mtd_mode_t  mode;
    logic [1:0] nbytes;
    logic [2:0] ncyc;
    logic [2:0] ridx;
  } mtd_dec_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mtd_mem_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } mtd_tick_state_t;

  typedef struct packed {
    mtd_fsm_t    fsm;
    mtd_word_t   acc;
    mtd_word_t   tmp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [15:0] pc;
    mtd_psw_t    psw;
    logic [7:0]  opcode;
    mtd_dir_t    opnd0;
    logic [7:0]  opnd1;
    logic [1:0]  ocnt;
    logic [2:0]  cyc;
    logic [7:0]  rdata;
    mtd_mem_t    mem;
    logic        done;
    logic        unsup;
  } mtd_core_state_t;

endpackage : mtd_pkg

// *** mtd_tick_gen.sv ***
// instruction cycle enable generator
`timescale 1ns/100ps
`default_nettype none
`include "mtd_map.svh"

module mtd_tick_gen (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       use_sub_i,
  input  wire logic [1:0] gear_i,
  input  wire logic       sub_tick_i,
  output logic            tick_o
);

  mtd_pkg::mtd_tick_state_t st_r;
  mtd_pkg::mtd_tick_state_t st_nxt;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    logic [6:0] div;
    div = `MTD_DIV_G0;
    if (use_sub_i) begin
      div = `MTD_DIV_SUB;
    end else begin
      unique case (gear_i)
        2'h0: div = `MTD_DIV_G0;
        2'h1: div = `MTD_DIV_G1;
        2'h2: div = `MTD_DIV_G2;
        2'h3: div = `MTD_DIV_G3;
      endcase
    end
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    // subclock periods arrive as enables; main periods are every clock
    if (!use_sub_i || sub_tick_i) begin
      if (st_r.cnt >= div - 7'h01) begin
        st_nxt.cnt  = 7'h00;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

  tick_gap_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    tick_o |=> !tick_o)
    else $error("instruction cycle shorter than two clocks");

endmodule : mtd_tick_gen
`default_nettype wire
